// ### logic/wdtu_pkg.sv
// Package of constants and types for the watchdog timer unit.
package wdtu_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [13:0] WDTU_IDX_OPTION   = 14'h0081;
  localparam logic [13:0] WDTU_IDX_OPTION_M = 14'h0181;
  localparam logic [13:0] WDTU_IDX_CONFIG   = 14'h2007;
  localparam logic [13:0] WDTU_IDX_STATUS   = 14'h0010;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int          WDTU_CFG_EN_BIT    = 3;
  localparam int          WDTU_OPT_PSA_BIT   = 3;
  localparam int          WDTU_ST_FLAG_BIT   = 0;
  localparam int          WDTU_ST_SLEEP_BIT  = 1;
  localparam int          WDTU_ST_EN_BIT     = 2;
  localparam logic [7:0]  WDTU_OPT_RESET     = 8'hFF;
  localparam logic [7:0]  WDTU_CFG_RESET     = 8'h00;
  localparam logic [7:0]  WDTU_CNT_LAST      = 8'hFF;
  localparam logic [7:0]  WDTU_BYTE_ZERO     = 8'h00;
  localparam logic [31:0] WDTU_WORD_ZERO     = 32'h0000_0000;

  // ------------------------------------------------------------------
  // Timing of the modelled RC oscillator
  // ------------------------------------------------------------------
  localparam int          WDTU_CLK_PERIOD_NS = 10;
  localparam int          WDTU_OSC_PERIOD_NS = 1000;
  localparam int          WDTU_OSC_CYC       =
    WDTU_OSC_PERIOD_NS / WDTU_CLK_PERIOD_NS;
  localparam logic [6:0]  WDTU_OSC_LAST      = 7'(WDTU_OSC_CYC - 1);
  localparam logic [6:0]  WDTU_OSC_ZERO      = 7'h00;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    WDTU_ST_RUN   = 2'b01,
    WDTU_ST_SLEPT = 2'b10
  } wdtu_state_t;

  // Mask of 2**ratio - 1 postscaler counts.
  function automatic logic [7:0] wdtu_ratio_mask(input logic [2:0] ratio);
    wdtu_ratio_mask = 8'((9'h001 << ratio) - 9'h001);
  endfunction

endpackage

// ### logic/wdtu_scaler.sv
// Shared scaler that divides watchdog overflows by two to the ratio.
module wdtu_scaler
  import wdtu_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       clr_i,
  input  wire logic       inc_i,
  input  wire logic [2:0] ratio_i,
  output logic            done_o
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  assign done_o = inc_i && ((cnt_ff & wdtu_ratio_mask(ratio_i)) ==
                            wdtu_ratio_mask(ratio_i)); // see R9

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clr_i || done_o) begin
      nxt_cnt = WDTU_BYTE_ZERO;
    end else if (inc_i) begin
      nxt_cnt = 8'(cnt_ff + 8'h01);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= WDTU_BYTE_ZERO;
    end else if (ce_i) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ### logic/wdtu_top.sv
// Watchdog timer unit with its register slave on classic Wishbone.
//
// Summary of operation
// R1 - Counter ticks from an internal free-running oscillator, not the CPU clock.
// R2 - When enabled, counting continues while the processor sleeps.
// R3 - Expiry in normal operation raises a full device reset.
// R4 - Expiry during sleep wakes the device instead of resetting.
// R5 - Every expiry clears the expiry status flag.
// R6 - Configuration bit 3 at zero disables the watchdog for good.
// R7 - Option register: bit 3 assigns scaler, bits 2..0 give the ratio.
// R8 - Sleep instruction clears the counter and the assigned scaler.
// R9 - With the scaler assigned, expiry rate divides by two to the ratio.
// R10 - The clear instruction resets counter and assigned scaler.
//
// The Wishbone register port was chosen for this implementation.
module wdtu_top
  import wdtu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [7:0]  cfg_word_i,
  input  wire logic        sleep_instr_i,
  input  wire logic        clear_instr_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             wdt_reset_o,
  output logic             wake_o,
  output logic             sleeping_o,
  output logic             expiry_status_flag_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [6:0]  osc_cnt_ff;
  logic [7:0]  wdt_cnt_ff;
  logic [7:0]  option_ff;
  logic [7:0]  config_ff;
  logic        cfg_loaded_ff;
  logic        flag_ff;
  logic        reset_ff;
  logic        wake_ff;
  logic        sleeping_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  wdtu_state_t state_ff;

  logic [6:0]  nxt_osc_cnt;
  logic [7:0]  nxt_wdt_cnt;
  logic [7:0]  nxt_option;
  logic [7:0]  nxt_config;
  logic        nxt_cfg_loaded;
  logic        nxt_flag;
  logic        nxt_reset;
  logic        nxt_wake;
  logic        nxt_sleeping;
  logic        nxt_ack;
  logic [31:0] nxt_dat;
  wdtu_state_t nxt_state;

  logic        osc_tick;
  logic        wdt_enable;
  logic        scaler_assign_select;
  logic        base_ovf;
  logic        scaler_done;
  logic        expiry;
  logic        wdt_clr;
  logic        bus_req;
  logic        bus_wr;
  logic [13:0] idx;

  function automatic logic idx_is(input logic [13:0] a,
                                  input logic [13:0] b);
    idx_is = (a == b);
  endfunction

  // ------------------------------------------------------------------
  // Time base and expiry
  // ------------------------------------------------------------------
  // The oscillator divider never looks at sleep: it stands for the RC
  // oscillator that keeps running while the processor clock is stopped.
  assign osc_tick    = (osc_cnt_ff == WDTU_OSC_LAST); // see R1
  assign wdt_enable  = config_ff[WDTU_CFG_EN_BIT] && cfg_loaded_ff; // see R6
  assign scaler_assign_select         = option_ff[WDTU_OPT_PSA_BIT];
  assign base_ovf    = wdt_enable && osc_tick &&
                       (wdt_cnt_ff == WDTU_CNT_LAST);
  assign expiry      = scaler_assign_select ? scaler_done : base_ovf; // see R9
  assign wdt_clr     = sleep_instr_i || clear_instr_i; // see R8 see R10

  wdtu_scaler u_scaler (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .clr_i   (wdt_clr && scaler_assign_select),
    .inc_i   (base_ovf && scaler_assign_select),
    .ratio_i (option_ff[2:0]),
    .done_o  (scaler_done)
  );

  always_comb begin
    nxt_osc_cnt = osc_tick ? WDTU_OSC_ZERO : 7'(osc_cnt_ff + 7'h01);
    nxt_wdt_cnt = wdt_cnt_ff;
    if (wdt_clr || !wdt_enable) begin
      nxt_wdt_cnt = WDTU_BYTE_ZERO; // see R8 see R10
    end else if (osc_tick) begin
      nxt_wdt_cnt = 8'(wdt_cnt_ff + 8'h01); // see R2
    end
  end

  // ------------------------------------------------------------------
  // Sleep state, reset and wake pulses, status flag
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_reset = 1'b0;
    nxt_wake  = 1'b0;
    nxt_flag  = flag_ff;
    unique case (state_ff)
      WDTU_ST_RUN: begin
        if (expiry) begin
          nxt_reset = 1'b1; // see R3
        end else if (sleep_instr_i) begin
          nxt_state = WDTU_ST_SLEPT;
        end
      end
      WDTU_ST_SLEPT: begin
        if (expiry) begin
          nxt_wake  = 1'b1; // see R4
          nxt_state = WDTU_ST_RUN;
        end
      end
      default: begin
        nxt_state = WDTU_ST_RUN;
      end
    endcase
    // Expiry wins over an instruction that sets the flag in the same cycle.
    if (expiry) begin
      nxt_flag = 1'b0; // see R5
    end else if (wdt_clr) begin
      nxt_flag = 1'b1;
    end
    nxt_sleeping = (nxt_state == WDTU_ST_SLEPT);
  end

  // ------------------------------------------------------------------
  // Wishbone slave and registers
  // ------------------------------------------------------------------
  assign idx     = adr_i[15:2];
  assign bus_req = cyc_i && stb_i && !ack_ff;
  assign bus_wr  = bus_req && we_i && sel_i[0];

  always_comb begin
    nxt_ack        = bus_req;
    nxt_dat        = WDTU_WORD_ZERO;
    nxt_option     = option_ff;
    nxt_config     = config_ff;
    nxt_cfg_loaded = 1'b1;
    // The strap is caught on the first enabled edge after reset release.
    if (!cfg_loaded_ff) begin
      nxt_config = cfg_word_i;
    end
    if (bus_wr && (idx_is(idx, WDTU_IDX_OPTION) ||
                   idx_is(idx, WDTU_IDX_OPTION_M))) begin
      nxt_option = dat_i[7:0]; // see R7
    end
    if (bus_req && !we_i) begin
      if (idx_is(idx, WDTU_IDX_OPTION) ||
          idx_is(idx, WDTU_IDX_OPTION_M)) begin
        nxt_dat[7:0] = option_ff;
      end else if (idx_is(idx, WDTU_IDX_CONFIG)) begin
        nxt_dat[7:0] = config_ff;
      end else if (idx_is(idx, WDTU_IDX_STATUS)) begin
        nxt_dat[WDTU_ST_FLAG_BIT]  = flag_ff;
        nxt_dat[WDTU_ST_SLEEP_BIT] = (state_ff == WDTU_ST_SLEPT);
        nxt_dat[WDTU_ST_EN_BIT]    = wdt_enable;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_cnt_ff    <= WDTU_OSC_ZERO;
      wdt_cnt_ff    <= WDTU_BYTE_ZERO;
      option_ff     <= WDTU_OPT_RESET;
      config_ff     <= WDTU_CFG_RESET;
      cfg_loaded_ff <= 1'b0;
      flag_ff       <= 1'b1;
      reset_ff      <= 1'b0;
      wake_ff       <= 1'b0;
      sleeping_ff   <= 1'b0;
      ack_ff        <= 1'b0;
      dat_ff        <= WDTU_WORD_ZERO;
      state_ff      <= WDTU_ST_RUN;
    end else if (ce_i) begin
      osc_cnt_ff    <= nxt_osc_cnt;
      wdt_cnt_ff    <= nxt_wdt_cnt;
      option_ff     <= nxt_option;
      config_ff     <= nxt_config;
      cfg_loaded_ff <= nxt_cfg_loaded;
      flag_ff       <= nxt_flag;
      reset_ff      <= nxt_reset;
      wake_ff       <= nxt_wake;
      sleeping_ff   <= nxt_sleeping;
      ack_ff        <= nxt_ack;
      dat_ff        <= nxt_dat;
      state_ff      <= nxt_state;
    end
  end

  assign dat_o                = dat_ff;
  assign ack_o                = ack_ff;
  assign wdt_reset_o          = reset_ff;
  assign wake_o               = wake_ff;
  assign sleeping_o           = sleeping_ff;
  assign expiry_status_flag_o = flag_ff;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_osc_wrap;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && osc_tick |=> osc_cnt_ff == WDTU_OSC_ZERO;
  endproperty
  a_osc_wrap: assert property (p_osc_wrap) // see R1
    else $error("Oscillator divider did not wrap.");

  property p_sleep_count;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && sleeping_o && wdt_enable && osc_tick && !wdt_clr &&
      wdt_cnt_ff != WDTU_CNT_LAST |=> wdt_cnt_ff == $past(wdt_cnt_ff) + 8'h01;
  endproperty
  a_sleep_count: assert property (p_sleep_count) // see R2
    else $error("Watchdog stopped counting during sleep.");

  property p_reset_on_expiry;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && expiry && state_ff == WDTU_ST_RUN |=> wdt_reset_o && !wake_o;
  endproperty
  a_reset_on_expiry: assert property (p_reset_on_expiry) // see R3
    else $error("Expiry in run did not reset the device.");

  property p_wake_on_expiry;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && expiry && sleeping_o |=> wake_o && !sleeping_o && !wdt_reset_o;
  endproperty
  a_wake_on_expiry: assert property (p_wake_on_expiry) // see R4
    else $error("Expiry in sleep did not wake the device.");

  property p_flag_clear;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && expiry |=> !expiry_status_flag_o;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // see R5
    else $error("Expiry did not clear the status flag.");

  property p_disabled;
    @(posedge clk_i) disable iff (rst_i)
      cfg_loaded_ff && !config_ff[WDTU_CFG_EN_BIT] |=> !wdt_reset_o && !wake_o;
  endproperty
  a_disabled: assert property (p_disabled) // see R6
    else $error("Disabled watchdog produced an event.");

  property p_option_write;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && bus_wr && idx_is(idx, WDTU_IDX_OPTION) |=>
      option_ff == $past(dat_i[7:0]);
  endproperty
  a_option_write: assert property (p_option_write) // see R7
    else $error("Option register write was lost.");

  property p_sleep_clear;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && sleep_instr_i |=> wdt_cnt_ff == WDTU_BYTE_ZERO;
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) // see R8
    else $error("Sleep instruction did not clear the counter.");

  property p_scaled;
    @(posedge clk_i) disable iff (rst_i)
      scaler_assign_select && base_ovf && u_scaler.cnt_ff == WDTU_BYTE_ZERO |->
      expiry == (option_ff[2:0] == 3'h0);
  endproperty
  a_scaled: assert property (p_scaled) // see R9
    else $error("Scaler fired on the wrong overflow.");

  property p_clear_instr;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && clear_instr_i && !expiry |=>
      wdt_cnt_ff == WDTU_BYTE_ZERO && expiry_status_flag_o;
  endproperty
  a_clear_instr: assert property (p_clear_instr) // see R10
    else $error("Clear instruction did not restart the watchdog.");

endmodule

// ### verification/wdtu_top_bench.sv
// Self-checking testbench for the watchdog timer unit.
module wdtu_top_bench
  import wdtu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals and register access table
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [7:0]  wd;
    logic [7:0]  exp;
  } wdtu_row_t;

  logic        clk_i;
  logic        rst_i;
  logic        ce_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [15:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [7:0]  cfg_word_i;
  logic        sleep_instr_i;
  logic        clear_instr_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        wdt_reset_o;
  logic        wake_o;
  logic        sleeping_o;
  logic        expiry_status_flag_o;
  int          mismatches;
  int          tests_run;
  logic [31:0] rd;
  logic        ev;
  wdtu_row_t   rows [12];

  wdtu_top i_wdtu_top (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .ce_i                 (ce_i),
    .cyc_i                (cyc_i),
    .stb_i                (stb_i),
    .we_i                 (we_i),
    .adr_i                (adr_i),
    .sel_i                (sel_i),
    .dat_i                (dat_i),
    .cfg_word_i           (cfg_word_i),
    .sleep_instr_i        (sleep_instr_i),
    .clear_instr_i        (clear_instr_i),
    .dat_o                (dat_o),
    .ack_o                (ack_o),
    .wdt_reset_o          (wdt_reset_o),
    .wake_o               (wake_o),
    .sleeping_o           (sleeping_o),
    .expiry_status_flag_o (expiry_status_flag_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; the request is held until ack is sampled high.
  task automatic wb(input logic we, input logic [15:0] adr,
                    input logic [3:0] sel, input logic [7:0] wd,
                    output logic [31:0] data);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= adr;
    sel_i <= sel;
    dat_i <= {24'h00_0000, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      mismatches++;
      $display("Error bus_ack expected 1 seen %b", ack_o);
      stop_test();
    end
    data = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic instr(input logic slp);
    if (slp) begin
      sleep_instr_i <= 1'b1;
    end else begin
      clear_instr_i <= 1'b1;
    end
    @(posedge clk_i);
    sleep_instr_i <= 1'b0;
    clear_instr_i <= 1'b0;
  endtask

  // Waits for one expiry pulse and checks when it came and its effects.
  task automatic wait_expiry(input logic wk, input int lo, input int hi);
    int   n;
    logic hit;
    n   = 0;
    hit = 1'b0;
    while (!hit && n < hi + 5) begin
      @(posedge clk_i);
      n++;
      hit = wk ? (wake_o === 1'b1) : (wdt_reset_o === 1'b1);
      if ((wk ? wdt_reset_o : wake_o) !== 1'b0) begin
        chk("wrong_event", 32'h0, 32'h1);
      end
    end
    if (!hit) begin
      mismatches++;
      $display("Error expiry expected pulse seen none");
      stop_test();
    end
    chk("expiry_not_early", 32'h1, 32'(n >= lo));
    chk("expiry_not_late", 32'h1, 32'(n <= hi));
    @(posedge clk_i);
    chk("pulse_width", 32'h0, 32'(wk ? wake_o : wdt_reset_o));
    chk("status_flag", 32'h0, 32'(expiry_status_flag_o));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mismatches = 0;
    tests_run = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 16'h0000;
    sel_i = 4'h0;
    dat_i = 32'h0000_0000;
    cfg_word_i = 8'h08;
    sleep_instr_i = 1'b0;
    clear_instr_i = 1'b0;
    rows = '{
      '{1'b0, 16'h0204, 4'hF, 8'h00, WDTU_OPT_RESET},
      '{1'b1, 16'h0204, 4'hF, 8'h08, 8'h00},
      '{1'b0, 16'h0204, 4'hF, 8'h00, 8'h08},
      '{1'b0, 16'h0604, 4'hF, 8'h00, 8'h08},
      '{1'b1, 16'h0604, 4'hF, 8'h55, 8'h00},
      '{1'b0, 16'h0204, 4'hF, 8'h00, 8'h55},
      '{1'b1, 16'h0204, 4'h0, 8'hAA, 8'h00},
      '{1'b0, 16'h0204, 4'hF, 8'h00, 8'h55},
      '{1'b1, 16'h801C, 4'hF, 8'h00, 8'h00},
      '{1'b0, 16'h801C, 4'hF, 8'h00, 8'h08},
      '{1'b1, 16'h0100, 4'hF, 8'h33, 8'h00},
      '{1'b0, 16'h0100, 4'hF, 8'h00, 8'h00}
    };
    repeat (16) @(posedge clk_i);
    chk("reset_outputs", 32'h1, 32'({ack_o, wdt_reset_o, wake_o,
        sleeping_o, expiry_status_flag_o}));
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].sel, rows[i].wd, rd);
      if (!rows[i].we) begin
        chk("reg_read", {24'h00_0000, rows[i].exp}, rd);
      end
    end
    wb(1'b0, 16'h0040, 4'hF, 8'h00, rd);
    chk("status_enabled", 32'h5, rd);
    // With the clock enable low a sleep instruction must leave no trace.
    ce_i <= 1'b0;
    instr(1'b1);
    @(posedge clk_i);
    chk("frozen_sleeping", 32'h0, 32'(sleeping_o));
    ce_i <= 1'b1;
    // Scaler assigned with ratio one: two overflows, woken from sleep.
    wb(1'b1, 16'h0204, 4'hF, 8'h09, rd);
    instr(1'b1);
    @(posedge clk_i);
    chk("sleeping", 32'h1, 32'(sleeping_o));
    wait_expiry(1'b1, 51090, 51220);
    chk("awake", 32'h0, 32'(sleeping_o));
    wb(1'b0, 16'h0040, 4'hF, 8'h00, rd);
    chk("status_after_wake", 32'h4, rd);
    // Unassigned scaler; a second clear mid-count must restart the period.
    wb(1'b1, 16'h0204, 4'hF, 8'h00, rd);
    instr(1'b0);
    @(posedge clk_i);
    chk("flag_after_clear", 32'h1, 32'(expiry_status_flag_o));
    repeat (300) @(posedge clk_i);
    instr(1'b0);
    wait_expiry(1'b0, 25490, 25620);
    // Disabled by the strap: nothing may expire.
    cfg_word_i <= 8'hF7;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 16'h0040, 4'hF, 8'h00, rd);
    chk("status_disabled", 32'h1, rd);
    // Shortest period selected, so an enabled watchdog would expire here.
    wb(1'b1, 16'h0204, 4'hF, 8'h00, rd);
    ev = 1'b0;
    repeat (25700) begin
      @(posedge clk_i);
      ev = ev | wdt_reset_o | wake_o;
    end
    chk("disabled_event", 32'h0, 32'(ev));
    stop_test();
  end

endmodule
